// *** shared/cdg_pkg.sv ***
// ==========================================================
// Register map, field positions and state codes
package cdg_pkg;
  // Register bus widths and dead-band count width
  localparam int unsigned CDG_AW = 3;
  localparam int unsigned CDG_DW = 8;
  localparam int unsigned CDG_DBW = 6;

  // Register offsets
  localparam logic [2:0] CDG_OFF_CTRL0 = 3'h0;
  localparam logic [2:0] CDG_OFF_CTRL1 = 3'h1;
  localparam logic [2:0] CDG_OFF_DBR = 3'h2;
  localparam logic [2:0] CDG_OFF_DBF = 3'h3;
  localparam logic [2:0] CDG_OFF_STAT = 3'h4;

  // Control register 0 fields
  localparam int unsigned CDG_C0_ON = 7;
  localparam int unsigned CDG_C0_OE_B = 6;
  localparam int unsigned CDG_C0_OE_A = 5;
  localparam int unsigned CDG_C0_POL_B = 4;
  localparam int unsigned CDG_C0_POL_A = 3;
  localparam int unsigned CDG_C0_CLKSEL = 0;

  // Control register 1 fields
  localparam int unsigned CDG_C1_FORCE = 7;
  localparam int unsigned CDG_C1_OVR_B = 5;
  localparam int unsigned CDG_C1_OVR_A = 4;
  localparam int unsigned CDG_C1_ISEL = 0;

  // Reset values
  localparam logic [7:0] CDG_RST_CTRL0 = 8'h00;
  localparam logic [7:0] CDG_RST_CTRL1 = 8'h00;
  localparam logic [5:0] CDG_RST_DB = 6'h00;

  // Input source codes
  localparam logic [1:0] CDG_SRC_CMP1 = 2'h0;
  localparam logic [1:0] CDG_SRC_CMP2 = 2'h1;
  localparam logic [1:0] CDG_SRC_PWM1 = 2'h2;
  localparam logic [1:0] CDG_SRC_PWM2 = 2'h3;

  // Clock rates of the two dead-band time bases
  localparam int unsigned CDG_SYS_FREQ_HZ = 20_000_000;
  localparam int unsigned CDG_OSC_FREQ_HZ = 16_000_000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RISE_DB = 3'b001,
    ST_A_ON = 3'b010,
    ST_FALL_DB = 3'b011,
    ST_B_ON = 3'b100
  } cdg_state_t;
endpackage : cdg_pkg

// *** rtl/cdg_db_counter.sv ***
`timescale 1ns/10ps
// ==========================================================
// Dead-band counter, one per edge direction
module cdg_db_counter
  import cdg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic tick,
  input wire logic [CDG_DBW-1:0] limit,
  output logic done
);
  logic [CDG_DBW-1:0] count_q;

  // Counts generator clock ticks from zero, saturating at the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      if (clear) begin
        count_q <= '0;
      end else if (tick && (count_q != limit)) begin
        count_q <= count_q + 6'h01;
      end
    end
  end

  // Level, reached once the count has met the limit
  assign done = (count_q == limit);
endmodule : cdg_db_counter

// *** rtl/cdg_top.sv ***
`timescale 1ns/10ps
// ==========================================================
module cdg_top
  import cdg_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  input wire logic [CDG_AW-1:0] addr,
  input wire logic [CDG_DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [CDG_DW-1:0] rd_data,
  input wire logic comparator_one_result,
  input wire logic comparator_two_result,
  input wire logic pulse_gen_one_output,
  input wire logic pulse_gen_two_output,
  input wire logic internal_fast_oscillator,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_a_oe,
  output logic wave_b_oe
);
  // ==========================================================
  // Control registers
  logic generator_on_bit_q;
  logic pin_a_drive_enable_q;
  logic pin_b_drive_enable_q;
  logic pin_a_polarity_q;
  logic pin_b_polarity_q;
  logic deadband_clock_select_q;
  logic force_override_q;
  logic override_a_q;
  logic override_b_q;
  logic [1:0] input_source_select_q;
  logic [CDG_DBW-1:0] rising_deadband_count_q;
  logic [CDG_DBW-1:0] falling_deadband_count_q;
  logic [CDG_DW-1:0] rd_data_q;

  // Sequencer and edge logic
  cdg_state_t state_q;
  cdg_state_t state_d;
  logic src_now;
  logic src_q;
  logic rise;
  logic fall;
  logic osc_q;
  logic osc_rise;
  logic tick;
  logic rise_clr;
  logic fall_clr;
  logic rise_done;
  logic fall_done;
  logic a_on_d;
  logic b_on_d;
  logic level_a_d;
  logic level_b_d;
  logic wave_a_q;
  logic wave_b_q;
  logic oe_a_q;
  logic oe_b_q;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      generator_on_bit_q <= CDG_RST_CTRL0[CDG_C0_ON];
      pin_b_drive_enable_q <= CDG_RST_CTRL0[CDG_C0_OE_B];
      pin_a_drive_enable_q <= CDG_RST_CTRL0[CDG_C0_OE_A];
      pin_b_polarity_q <= CDG_RST_CTRL0[CDG_C0_POL_B];
      pin_a_polarity_q <= CDG_RST_CTRL0[CDG_C0_POL_A];
      deadband_clock_select_q <= CDG_RST_CTRL0[CDG_C0_CLKSEL];
      force_override_q <= CDG_RST_CTRL1[CDG_C1_FORCE];
      override_b_q <= CDG_RST_CTRL1[CDG_C1_OVR_B];
      override_a_q <= CDG_RST_CTRL1[CDG_C1_OVR_A];
      input_source_select_q <= CDG_RST_CTRL1[CDG_C1_ISEL +: 2];
      rising_deadband_count_q <= CDG_RST_DB;
      falling_deadband_count_q <= CDG_RST_DB;
    end else if (ce && wr_en) begin
      unique case (addr)
        CDG_OFF_CTRL0: begin
          generator_on_bit_q <= wr_data[CDG_C0_ON];
          pin_b_drive_enable_q <= wr_data[CDG_C0_OE_B];
          pin_a_drive_enable_q <= wr_data[CDG_C0_OE_A];
          pin_b_polarity_q <= wr_data[CDG_C0_POL_B];
          pin_a_polarity_q <= wr_data[CDG_C0_POL_A];
          deadband_clock_select_q <= wr_data[CDG_C0_CLKSEL];
        end
        CDG_OFF_CTRL1: begin
          force_override_q <= wr_data[CDG_C1_FORCE];
          override_b_q <= wr_data[CDG_C1_OVR_B];
          override_a_q <= wr_data[CDG_C1_OVR_A];
          input_source_select_q <= wr_data[CDG_C1_ISEL +: 2];
        end
        CDG_OFF_DBR: rising_deadband_count_q <= wr_data[CDG_DBW-1:0];
        CDG_OFF_DBF: falling_deadband_count_q <= wr_data[CDG_DBW-1:0];
        default: ; // Writes to unmapped or read-only offsets are dropped
      endcase
    end
  end

  // ==========================================================
  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (ce) begin
      rd_data_q <= 8'h00;
      if (rd_en) begin
        unique case (addr)
          CDG_OFF_CTRL0: rd_data_q <= {generator_on_bit_q, pin_b_drive_enable_q, pin_a_drive_enable_q,
                                       pin_b_polarity_q, pin_a_polarity_q, 2'b00, deadband_clock_select_q};
          CDG_OFF_CTRL1: rd_data_q <= {force_override_q, 1'b0, override_b_q, override_a_q,
                                       2'b00, input_source_select_q};
          CDG_OFF_DBR: rd_data_q <= {2'b00, rising_deadband_count_q};
          CDG_OFF_DBF: rd_data_q <= {2'b00, falling_deadband_count_q};
          CDG_OFF_STAT: rd_data_q <= {2'b00, state_q, src_q, wave_a_q, wave_b_q};
          default: rd_data_q <= 8'h00; // Unmapped offsets read as zero
        endcase
      end
    end
  end

  // ==========================================================
  // Input source selection and edge detection
  always_comb begin
    unique case (input_source_select_q)
      CDG_SRC_CMP1: src_now = comparator_one_result;
      CDG_SRC_CMP2: src_now = comparator_two_result;
      CDG_SRC_PWM1: src_now = pulse_gen_one_output;
      CDG_SRC_PWM2: src_now = pulse_gen_two_output;
    endcase
  end

  // Previous input level; tracked even while off so enabling makes no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= 1'b0;
    end else if (ce) begin
      src_q <= src_now;
    end
  end

  assign rise = src_now & ~src_q;
  assign fall = ~src_now & src_q;

  // ==========================================================
  // Dead-band time base
  // The oscillator is sampled on clk, so its edges are only seen as far as clk resolves them;
  // the edge phase against the input is where the one-period uncertainty comes from.
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else if (ce) begin
      osc_q <= internal_fast_oscillator;
    end
  end

  assign osc_rise = internal_fast_oscillator & ~osc_q;
  assign tick = deadband_clock_select_q ? osc_rise : 1'b1;

  // Rising and falling counters run independently
  cdg_db_counter u_rise_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(rise_clr),
    .tick(tick),
    .limit(rising_deadband_count_q),
    .done(rise_done)
  );

  cdg_db_counter u_fall_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(fall_clr),
    .tick(tick),
    .limit(falling_deadband_count_q),
    .done(fall_done)
  );

  // ==========================================================
  // Sequencer; a new edge always restarts, which abandons any running count
  always_comb begin
    state_d = state_q;
    rise_clr = 1'b0;
    fall_clr = 1'b0;
    if (!generator_on_bit_q) begin
      state_d = ST_IDLE;
    end else if (rise) begin
      rise_clr = 1'b1;
      state_d = (rising_deadband_count_q == 6'h00) ? ST_A_ON : ST_RISE_DB;
    end else if (fall) begin
      fall_clr = 1'b1;
      state_d = (falling_deadband_count_q == 6'h00) ? ST_B_ON : ST_FALL_DB;
    end else begin
      unique case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_RISE_DB: if (rise_done) state_d = ST_A_ON;
        ST_A_ON: state_d = ST_A_ON;
        ST_FALL_DB: if (fall_done) state_d = ST_B_ON;
        ST_B_ON: state_d = ST_B_ON;
        default: state_d = ST_IDLE; // Recover from an illegal code
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Output levels: polarity on the waveform, overrides passed straight
  assign a_on_d = (state_d == ST_A_ON);
  assign b_on_d = (state_d == ST_B_ON);
  assign level_a_d = force_override_q ? override_a_q : (pin_a_polarity_q ? a_on_d : ~a_on_d);
  assign level_b_d = force_override_q ? override_b_q : (pin_b_polarity_q ? b_on_d : ~b_on_d);

  // Pins are registered so the switch drivers never see a combinational glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      oe_a_q <= 1'b0;
      oe_b_q <= 1'b0;
    end else if (ce) begin
      if (!generator_on_bit_q) begin
        wave_a_q <= 1'b0;
        wave_b_q <= 1'b0;
        oe_a_q <= 1'b0;
        oe_b_q <= 1'b0;
      end else begin
        wave_a_q <= level_a_d;
        wave_b_q <= level_b_d;
        oe_a_q <= pin_a_drive_enable_q;
        oe_b_q <= pin_b_drive_enable_q;
      end
    end
  end

  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  assign wave_a_oe = oe_a_q;
  assign wave_b_oe = oe_b_q;
  assign rd_data = rd_data_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_off_no_drive: assert property ((ce && !generator_on_bit_q) |=> (!wave_a_oe && !wave_b_oe))
    else $error("pins driven while generator off");

  a_oe_follows_bit: assert property ((ce && generator_on_bit_q) |=> (wave_a_oe == $past(pin_a_drive_enable_q)))
    else $error("pin A enable does not follow its bit");

  a_enable_starts_idle: assert property ((ce && $rose(generator_on_bit_q)) |-> (state_q == ST_IDLE))
    else $error("generator switched on outside idle");

  a_rise_b_off: assert property ((ce && generator_on_bit_q && rise && !force_override_q) |=>
    (wave_out_b == !$past(pin_b_polarity_q)))
    else $error("B not turned off on rising edge");

  a_fall_a_off: assert property ((ce && generator_on_bit_q && fall && !force_override_q) |=>
    (wave_out_a == !$past(pin_a_polarity_q)))
    else $error("A not turned off on falling edge");

  a_zero_db_direct: assert property ((ce && generator_on_bit_q && rise && rising_deadband_count_q == 6'h00) |=>
    (state_q == ST_A_ON))
    else $error("zero dead band still delayed");

  a_db_waits_count: assert property ((ce && state_q == ST_RISE_DB && !rise_done && !fall && generator_on_bit_q) |=>
    (state_q == ST_RISE_DB))
    else $error("rising dead band ended early");

  a_abort_keeps_off: assert property ((ce && state_q == ST_RISE_DB && fall && generator_on_bit_q) |=>
    (state_q != ST_A_ON) ##0 (state_q != ST_RISE_DB))
    else $error("abandoned count still turned A on");

  a_override_raw: assert property ((ce && generator_on_bit_q && force_override_q) |=>
    (wave_out_a == $past(override_a_q) && wave_out_b == $past(override_b_q)))
    else $error("override level altered");

  a_sysclk_tick: assert property ((!deadband_clock_select_q) |-> tick)
    else $error("system clock base misses a tick");

  a_src_select: assert property ((input_source_select_q == CDG_SRC_PWM2) |-> (src_now == pulse_gen_two_output))
    else $error("wrong input source");

  // Mirrored checks for the B side, the off state and the shoot-through guard
  a_b_oe_follows_bit: assert property ((ce && generator_on_bit_q) |=>
    (wave_b_oe == $past(pin_b_drive_enable_q)))
    else $error("pin B enable does not follow its bit");

  a_off_pins_low: assert property ((ce && !generator_on_bit_q) |=> (!wave_out_a && !wave_out_b))
    else $error("pin levels not cleared while generator off");

  a_no_overlap: assert property ((ce && generator_on_bit_q && !force_override_q) |=>
    !((wave_out_a == $past(pin_a_polarity_q)) && (wave_out_b == $past(pin_b_polarity_q))))
    else $error("both outputs active together");

  a_a_needs_rise: assert property ((ce && generator_on_bit_q && !rise && state_q != ST_RISE_DB &&
    state_q != ST_A_ON) |=> (state_q != ST_A_ON))
    else $error("A turned on without a finished rising dead band");

  a_b_needs_fall: assert property ((ce && generator_on_bit_q && !fall && state_q != ST_FALL_DB &&
    state_q != ST_B_ON) |=> (state_q != ST_B_ON))
    else $error("B turned on without a finished falling dead band");

  a_fall_zero_db: assert property ((ce && generator_on_bit_q && fall && falling_deadband_count_q == 6'h00) |=>
    (state_q == ST_B_ON))
    else $error("zero falling dead band still delayed");

  a_fall_db_waits: assert property ((ce && state_q == ST_FALL_DB && !fall_done && !rise && !fall &&
    generator_on_bit_q) |=> (state_q == ST_FALL_DB))
    else $error("falling dead band ended early");

  a_abort_b_off: assert property ((ce && state_q == ST_FALL_DB && rise && generator_on_bit_q) |=>
    (state_q != ST_B_ON) ##0 (state_q != ST_FALL_DB))
    else $error("abandoned count still turned B on");

  c_rise_sequence: cover property (ce && state_q == ST_RISE_DB ##[1:70] state_q == ST_A_ON);
  c_fall_sequence: cover property (ce && state_q == ST_FALL_DB ##[1:70] state_q == ST_B_ON);
  c_abort: cover property (ce && state_q == ST_RISE_DB && fall);
  c_fall_abort: cover property (ce && state_q == ST_FALL_DB && rise);
  c_osc_base: cover property (deadband_clock_select_q && state_q == ST_FALL_DB ##1 state_q == ST_B_ON);
endmodule : cdg_top

// *** dv/cdg_switch_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Power switch driver pair fed by the two wave pins
module cdg_switch_model
  import cdg_pkg::*;
(
  input wire logic clk,
  input wire logic watch,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic oe_a,
  input wire logic oe_b,
  input wire logic act_a,
  input wire logic act_b,
  output logic on_a,
  output logic on_b,
  output logic overlap_seen
);
  // An undriven pin is held off by the gate pull-down, so no oe means no conduction
  assign on_a = oe_a && (pin_a === act_a);
  assign on_b = oe_b && (pin_b === act_b);
  // Shoot-through: both switches on in one cycle; only judged while the bench says so
  logic seen_q = 1'b0;
  always @(posedge clk) begin
    if (watch && on_a && on_b) seen_q <= 1'b1;
  end
  assign overlap_seen = seen_q;
endmodule : cdg_switch_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
// ==========================================================
// Bench signals and tables
module tb
  import cdg_pkg::*;
;
  logic clk, ce, rst, wr_en, rd_en, watch, on_a, on_b, overlap_seen;
  logic osc = 1'b0;
  logic wave_out_a, wave_out_b, wave_a_oe, wave_b_oe;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data;
  logic [3:0] src_in;
  logic [1:0] osc_cnt = 2'h0;
  int err_count, n_compared;
  localparam logic [5:0] RISE_TAB [4] = '{6'h00, 6'h05, 6'h3f, 6'h01};
  localparam logic [5:0] FALL_TAB [4] = '{6'h3f, 6'h00, 6'h02, 6'h07};
  localparam logic [2:0] REG_A [6] = '{CDG_OFF_CTRL0, CDG_OFF_CTRL1, CDG_OFF_DBR, CDG_OFF_DBF, CDG_OFF_STAT, 3'h5};
  localparam logic [7:0] REG_W [6] = '{8'h7f, 8'hff, 8'hff, 8'hc0, 8'hff, 8'hff};
  localparam logic [7:0] REG_R [6] = '{8'h79, 8'hb3, 8'h3f, 8'h00, 8'h00, 8'h00};

  cdg_top i_cdg_top (
    .clk(clk), .ce(ce), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .comparator_one_result(src_in[0]), .comparator_two_result(src_in[1]),
    .pulse_gen_one_output(src_in[2]), .pulse_gen_two_output(src_in[3]), .internal_fast_oscillator(osc),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_a_oe(wave_a_oe), .wave_b_oe(wave_b_oe));

  cdg_switch_model i_cdg_switch_model (
    .clk(clk), .watch(watch), .pin_a(wave_out_a), .pin_b(wave_out_b), .oe_a(wave_a_oe), .oe_b(wave_b_oe),
    .act_a(1'b1), .act_b(1'b1), .on_a(on_a), .on_b(on_b), .overlap_seen(overlap_seen));

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Slow stand-in for the fast oscillator: it is sampled on clk, so it must stay below half the clk rate
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    osc <= osc_cnt[1];
  end

  // ==========================================================
  // Compare, bus and timing helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("CHECK FAILED at %0t: delay %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_in

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk); // Idle edge, so back-to-back writes never assign the strobe twice in one step
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask : rd

  // Settled pin view {a_oe, b_oe, a, b}, sampled after the edge updates land
  task automatic pins(input logic [3:0] exp);
    repeat (2) @(posedge clk);
    #1 chk({4'h0, wave_a_oe, wave_b_oe, wave_out_a, wave_out_b}, {4'h0, exp});
    @(posedge clk);
  endtask : pins

  // Move one source and time the turn-off of one switch and the turn-on of the other
  task automatic edge_run(input int s, input logic lvl, output int t_off, output int t_on);
    int c;
    t_off = 0;
    t_on = 0;
    src_in[s] <= lvl;
    for (c = 1; c <= 300 && t_on == 0; c++) begin
      @(posedge clk);
      #1;
      if (t_off == 0 && !(lvl ? on_b : on_a)) t_off = c;
      if (lvl ? on_a : on_b) t_on = c;
    end
    @(posedge clk);
    if (t_on == 0) begin
      err_count++;
      $display("CHECK FAILED at %0t: output never turned on", $time);
      stop_test();
    end
  endtask : edge_run

  task automatic watch_sw(input logic side_a, input int n, inout logic seen);
    repeat (n) begin
      @(posedge clk);
      #1 seen = seen | (side_a ? on_a : on_b);
    end
    @(posedge clk);
  endtask : watch_sw

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] q;
    for (int i = 0; i < 6; i++) begin
      rd(REG_A[i], q);
      chk(q, 8'h00);
      wr(REG_A[i], REG_W[i]);
      rd(REG_A[i], q);
      chk(q, REG_R[i]);
      wr(REG_A[i], 8'h00);
    end
    $display("test regs done");
  endtask : t_regs

  task automatic t_enable();
    wr(CDG_OFF_CTRL0, 8'h60);
    pins(4'h0);
    wr(CDG_OFF_CTRL0, 8'hb0);
    #1 chk({5'h0, wave_a_oe, wave_b_oe, 1'b0}, 8'h04);
    pins(4'ha);
    wr(CDG_OFF_CTRL0, 8'hf0);
    pins(4'he);
    wr(CDG_OFF_CTRL0, 8'hf8);
    pins(4'hc);
    wr(CDG_OFF_CTRL0, 8'he0);
    wr(CDG_OFF_CTRL1, 8'h90);
    pins(4'he);
    wr(CDG_OFF_CTRL1, 8'h00);
    wr(CDG_OFF_CTRL0, 8'h78);
    pins(4'h0);
    $display("test enable done");
  endtask : t_enable

  task automatic t_sources();
    int t_off, t_on, n;
    watch <= 1'b1;
    wr(CDG_OFF_CTRL0, 8'hf8);
    for (int s = 0; s < 4; s++) begin
      wr(CDG_OFF_DBR, {2'h0, RISE_TAB[s]});
      wr(CDG_OFF_DBF, {2'h0, FALL_TAB[s]});
      wr(CDG_OFF_CTRL1, {6'h00, s[1:0]});
      src_in[(s + 1) % 4] <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk({6'h0, on_a, on_b}, {7'h0, s != 0});
      @(posedge clk);
      src_in[(s + 1) % 4] <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        edge_run(s, k % 2 == 0, t_off, t_on);
        n = (k % 2 == 0) ? int'(RISE_TAB[s]) : int'(FALL_TAB[s]);
        if (s != 0 || k != 0) chk_in(t_on - t_off, n, n + 1);
        chk_in(t_on, n + 1, n + 4);
      end
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_short();
    int t_off, t_on;
    logic seen;
    seen = 1'b0;
    wr(CDG_OFF_DBR, 8'h14);
    wr(CDG_OFF_DBF, 8'h03);
    src_in[3] <= 1'b1;
    watch_sw(1'b1, 8, seen);
    edge_run(3, 1'b0, t_off, t_on);
    chk_in(t_on, 3, 7);
    watch_sw(1'b1, 30, seen);
    chk({7'h0, seen}, 8'h00);
    // Roles swapped: a short low pulse must never turn B on
    seen = 1'b0;
    wr(CDG_OFF_DBR, 8'h03);
    wr(CDG_OFF_DBF, 8'h14);
    edge_run(3, 1'b1, t_off, t_on);
    chk_in(t_on, 4, 7);
    src_in[3] <= 1'b0;
    watch_sw(1'b0, 8, seen);
    edge_run(3, 1'b1, t_off, t_on);
    chk_in(t_on, 4, 7);
    watch_sw(1'b0, 30, seen);
    chk({7'h0, seen}, 8'h00);
    edge_run(3, 1'b0, t_off, t_on);
    chk_in(t_on, 21, 24);
    $display("test short pulse done");
  endtask : t_short

  task automatic t_clksel();
    int t_off, t_on;
    wr(CDG_OFF_CTRL0, 8'hf9);
    wr(CDG_OFF_DBR, 8'h04);
    wr(CDG_OFF_DBF, 8'h00);
    edge_run(3, 1'b1, t_off, t_on);
    chk_in(t_on - t_off, 12, 21);
    edge_run(3, 1'b0, t_off, t_on);
    chk_in(t_on - t_off, 0, 1);
    wr(CDG_OFF_CTRL0, 8'hf8);
    chk({7'h0, overlap_seen}, 8'h00);
    $display("test clock select done");
  endtask : t_clksel

  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    ce = 1'b1;
    rst = 1'b1;
    {addr, wr_data, wr_en, rd_en, src_in, watch} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_enable();
    t_sources();
    t_short();
    t_clksel();
    stop_test();
  end
endmodule : tb
